// File: common/crd_defines.svh
// Constants of the completer request path: widths, descriptor field
// positions, credit limits and buffer depth.
// Assumes nothing; included by the package and the interface.
`ifndef CRD_DEFINES_SVH
`define CRD_DEFINES_SVH
// ----------------------------------------------------------------------
// Channel shape
// ----------------------------------------------------------------------
`define CRD_CHAN_W 64
`define CRD_DESC_W 128
`define CRD_PAD_W ((`CRD_CHAN_W > `CRD_DESC_W) ? `CRD_CHAN_W : `CRD_DESC_W)
`define CRD_DESC_BEATS ((`CRD_CHAN_W == 64) ? 2 : 1)
`define CRD_USER_W 5
`define CRD_USER_SOP 4
`define CRD_FIFO_DEPTH 16
// ----------------------------------------------------------------------
// Descriptor fields
// ----------------------------------------------------------------------
`define CRD_AT_HI 1
`define CRD_AT_LO 0
`define CRD_ADDR_HI 63
`define CRD_ADDR_LO 2
`define CRD_CNT_HI 74
`define CRD_CNT_LO 64
`define CRD_TYPE_HI 78
`define CRD_TYPE_LO 75
`define CRD_BUS_HI 95
`define CRD_BUS_LO 88
`define CRD_FN_HI 87
`define CRD_FN_LO 80
`define CRD_TAG_HI 103
`define CRD_TAG_LO 96
`define CRD_TFN_HI 111
`define CRD_TFN_LO 104
`define CRD_BAR_HI 114
`define CRD_BAR_LO 112
`define CRD_VF_BASE 8'h40
`define CRD_IO_CNT 11'h001
`define CRD_TYPE_MEM_WR 4'h1
// ----------------------------------------------------------------------
// Credit counter
// ----------------------------------------------------------------------
`define CRD_CRED_W 6
`define CRD_CRED_MAX 6'h20
`define CRD_CRED_RST 6'h00
`endif

// File: common/crd_pkg.sv
// Types shared by both ends of the completer request channel.
// Assumes crd_defines.svh on the include path.
`include "crd_defines.svh"
package crd_pkg;
   typedef enum logic [1:0] {CRD_MEM, CRD_VDM, CRD_ATS, CRD_MSG} crd_layout_t;
   typedef enum logic [1:0] {DS_IDLE, DS_DESC, DS_PAY} crd_dst_t;
   typedef enum logic {HS_DESC, HS_PAY} crd_hst_t;

   // One request as handed over by the link side
   typedef struct packed {
      crd_layout_t layout;
      logic is_io;
      logic zero_len;
      logic addr64;
      logic has_pay;
      logic [1:0] addr_type;
      logic [63:0] addr;
      logic [10:0] dw_cnt;
      logic [3:0] req_type;
      logic [7:0] bus;
      logic [4:0] dev;
      logic [7:0] fn;
      logic [7:0] tag;
      logic tgt_vf;
      logic [2:0] tgt_idx;
      logic [2:0] bar_id;
      logic [7:0] msg_code;
      logic [2:0] msg_route;
      logic [63:0] msg_hdr;
      logic [3:0] fbe;
   } crd_req_t;
endpackage

// File: common/crd_if.sv
// Completer request stream between the device end and the client end.
// Both ends share ref_clk_i; the bench joins them through this bundle.
`timescale 1ns/10ps
`default_nettype none
`include "crd_defines.svh"
interface crd_if;
   logic [`CRD_CHAN_W-1:0] tdata;
   logic tvalid;
   logic tready;
   logic tlast;
   logic [`CRD_USER_W-1:0] tuser;
   logic credit_grant;

   modport dev (output tdata, output tvalid, output tlast, output tuser,
      input tready, input credit_grant);
   modport host (input tdata, input tvalid, input tlast, input tuser,
      output tready, output credit_grant);
endinterface
`default_nettype wire

// File: rtl/crd_dev.sv
// Device end of the completer request channel, with its payload buffer.
// Assumes one clock ref_clk_i and a synchronous active-high reset.
//
// What this block does
// - Everything runs on one client clock.
// - Channel width is 64, 128 or 256.
// - Request path never waits on completions.
// - Each request leaves as its own packet.
// - Descriptor is sixteen bytes, packet start.
// - Two beats at 64 bits, else one.
// - Four layouts: memory, vendor, ATS, other.
// - Bits 1:0 carry address type.
// - Bits 63:2 Dword address, upper zero if short.
// - Bits 74:64 Dword count, 0 to 256.
// - I/O access reports count one.
// - Zero length: count one, enables zero.
// - Bits 78:75 carry request type.
// - Bits 95:80 requester ID, legacy split.
// - ARI: bus then eight-bit function.
// - Client keeps requester ID for completion.
// - Client keeps tag for non-posted requests.
// - Bits 111:104 targeted function from match.
// - Without ARI only low three bits valid.
// - Values 0,1 PFs; 64-69 VFs.
// - Client derives byte address from enables.
// - Non-posted only with credit; posted flows.
`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------------------------------------
// Payload buffer
// ----------------------------------------------------------------------
module crd_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic srst_i,
   // Fill side
   input wire logic in_valid_i,
   input wire logic [WIDTH-1:0] in_data_i,
   output logic in_ready_o,
   // Drain side
   output logic out_valid_o,
   output logic [WIDTH-1:0] out_data_o,
   input wire logic out_ready_i
);
   localparam int AW = $clog2(DEPTH);
   typedef struct packed {
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [AW:0] cnt;
      logic full;
      logic empty;
   } crd_fifo_st_t;

   crd_fifo_st_t q, n;
   logic [WIDTH-1:0] mem [DEPTH];
   logic push, pop;

   assign push = in_valid_i & ~q.full;
   assign pop = out_ready_i & ~q.empty;

   always_comb begin
      n = q;
      if (push) begin
         n.wp = (q.wp == AW'(DEPTH - 1)) ? '0 : q.wp + 1'b1;
      end
      if (pop) begin
         n.rp = (q.rp == AW'(DEPTH - 1)) ? '0 : q.rp + 1'b1;
      end
      n.cnt = q.cnt + (AW+1)'(push) - (AW+1)'(pop);
      n.full = (n.cnt == (AW+1)'(DEPTH));
      n.empty = (n.cnt == '0);
   end

   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         q <= '{wp: '0, rp: '0, cnt: '0, full: 1'b0, empty: 1'b1};
      end else begin
         q <= n;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (push) begin
         mem[q.wp] <= in_data_i;
      end
   end

   assign in_ready_o = ~q.full;
   assign out_valid_o = ~q.empty;
   assign out_data_o = mem[q.rp];
endmodule

// ----------------------------------------------------------------------
// Device end
// ----------------------------------------------------------------------
module crd_dev
   import crd_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic srst_i,
   // Configuration
   input wire logic ari_en_i,
   // Posted request headers
   input wire logic p_valid_i,
   input wire crd_req_t p_req_i,
   output logic p_ready_o,
   // Non-posted request headers
   input wire logic np_valid_i,
   input wire crd_req_t np_req_i,
   output logic np_ready_o,
   // Payload words, in order of header acceptance
   input wire logic pay_valid_i,
   input wire logic [`CRD_CHAN_W-1:0] pay_data_i,
   input wire logic pay_last_i,
   output logic pay_ready_o,
   // Completer request channel
   crd_if.dev ch
);
   localparam int CW = `CRD_CHAN_W;
   localparam int PW = `CRD_PAD_W;

   typedef struct packed {
      crd_dst_t st;
      logic [1:0] beats;
      logic [PW-1:0] sr;
      logic has_pay;
      logic done;
      logic tvalid;
      logic tlast;
      logic [CW-1:0] tdata;
      logic [`CRD_USER_W-1:0] tuser;
      logic [`CRD_CRED_W-1:0] cred;
      logic p_rdy;
      logic np_rdy;
   } crd_dev_st_t;

   crd_dev_st_t q, n;
   logic f_valid, f_pop, f_last;
   logic [CW-1:0] f_data;

   crd_fifo #(
      .WIDTH(CW + 1),
      .DEPTH(`CRD_FIFO_DEPTH)
   ) u_fifo (
      .ref_clk_i(ref_clk_i),
      .srst_i(srst_i),
      .in_valid_i(pay_valid_i),
      .in_data_i({pay_last_i, pay_data_i}),
      .in_ready_o(pay_ready_o),
      .out_valid_o(f_valid),
      .out_data_o({f_last, f_data}),
      .out_ready_i(f_pop)
   );

   // Builds the sixteen-byte descriptor for one request
   function automatic logic [`CRD_DESC_W-1:0] build_desc(crd_req_t r,
         logic ari);
      logic [`CRD_DESC_W-1:0] d;
      logic [7:0] tf;
      d = '0;
      tf = {5'h0, r.tgt_idx};
      if (r.layout == CRD_MEM) begin
         if (!r.is_io) begin
            d[`CRD_AT_HI:`CRD_AT_LO] = r.addr_type;
         end
         d[`CRD_ADDR_HI:`CRD_ADDR_LO] = r.addr64 ? r.addr[63:2] :
            {32'h0, r.addr[31:2]};
         if (r.tgt_vf) begin
            tf = `CRD_VF_BASE | {5'h0, r.tgt_idx};
         end
         if (!ari) begin
            tf[7:3] = 5'h00;
         end
         d[`CRD_TFN_HI:`CRD_TFN_LO] = tf;
         d[`CRD_BAR_HI:`CRD_BAR_LO] = r.bar_id;
      end else begin
         d[63:0] = r.msg_hdr;
         d[`CRD_TFN_HI:`CRD_TFN_LO] = r.msg_code;
         d[`CRD_BAR_HI:`CRD_BAR_LO] = r.msg_route;
      end
      d[`CRD_CNT_HI:`CRD_CNT_LO] = (r.is_io | r.zero_len) ? `CRD_IO_CNT :
         r.dw_cnt;
      d[`CRD_TYPE_HI:`CRD_TYPE_LO] = r.req_type;
      d[`CRD_BUS_HI:`CRD_BUS_LO] = r.bus;
      d[`CRD_FN_HI:`CRD_FN_LO] = ari ? r.fn :
         {r.dev, r.fn[2:0]};
      d[`CRD_TAG_HI:`CRD_TAG_LO] = r.tag;
      return d;
   endfunction

   always_comb begin
      crd_req_t r;
      logic [PW-1:0] dp;
      logic take, acc, inc, dec;
      r = p_req_i;
      dp = '0;
      take = 1'b0;
      dec = 1'b0;
      n = q;
      f_pop = 1'b0;
      acc = q.tvalid & ch.tready;
      // A grant and a debit in one cycle both count, unless the count sits at CRD_CRED_MAX
      inc = ch.credit_grant & (q.cred != `CRD_CRED_MAX);
      case (q.st)
         DS_IDLE: begin
            if (p_valid_i && q.p_rdy) begin
               take = 1'b1;
            end else if (np_valid_i && q.np_rdy) begin
               r = np_req_i;
               take = 1'b1;
               dec = 1'b1;
            end
            if (take) begin
               dp[`CRD_DESC_W-1:0] = build_desc(r, ari_en_i);
               n.tdata = dp[CW-1:0];
               n.sr = dp >> CW;
               n.beats = 2'(`CRD_DESC_BEATS - 1);
               n.tvalid = 1'b1;
               n.tlast = ~r.has_pay & (`CRD_DESC_BEATS == 1);
               n.tuser = {1'b1, r.zero_len ? 4'h0 : r.fbe};
               n.has_pay = r.has_pay;
               n.st = DS_DESC;
            end
         end
         DS_DESC: begin
            if (acc) begin
               if (q.beats != 2'h0) begin
                  n.tdata = q.sr[CW-1:0];
                  n.sr = q.sr >> CW;
                  n.beats = q.beats - 2'h1;
                  n.tuser = '0;
                  n.tlast = ~q.has_pay & (q.beats == 2'h1);
               end else begin
                  n.tvalid = 1'b0;
                  n.tlast = 1'b0;
                  n.tuser = '0;
                  n.done = 1'b0;
                  n.st = q.has_pay ? DS_PAY : DS_IDLE;
               end
            end
         end
         DS_PAY: begin
            if (!q.tvalid || acc) begin
               n.tvalid = 1'b0;
               n.tlast = 1'b0;
               if (!q.done && f_valid) begin
                  f_pop = 1'b1;
                  n.tdata = f_data;
                  n.tlast = f_last;
                  n.tvalid = 1'b1;
                  n.done = f_last;
               end else if (q.done) begin
                  n.st = DS_IDLE;
               end
            end
         end
         default: begin
            n.st = DS_IDLE;
         end
      endcase
      n.cred = q.cred + `CRD_CRED_W'(inc) - `CRD_CRED_W'(dec);
      // Posted headers stay admissible while credit is zero
      n.p_rdy = (n.st == DS_IDLE) & ~take;
      n.np_rdy = (n.st == DS_IDLE) & ~take & (n.cred != '0);
   end

   // Nothing here looks at a completion path, so requests never stall
   // behind one
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         q <= '0;
         q.st <= DS_IDLE;
         q.cred <= `CRD_CRED_RST;
      end else begin
         q <= n;
      end
   end

   assign p_ready_o = q.p_rdy;
   assign np_ready_o = q.np_rdy;
   assign ch.tvalid = q.tvalid;
   assign ch.tdata = q.tdata;
   assign ch.tlast = q.tlast;
   assign ch.tuser = q.tuser;
endmodule
`default_nettype wire

// File: rtl/crd_host.sv
// Client end of the completer request channel: unpacks descriptors,
// keeps IDs for completions and grants non-posted credit.
// Assumes the device end on the same ref_clk_i.
`timescale 1ns/10ps
`default_nettype none
module crd_host
   import crd_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic srst_i,
   // User flow control
   input wire logic host_ready_i,
   input wire logic np_buf_free_i,
   // Decoded request
   output logic req_valid_o,
   output logic [3:0] req_type_o,
   output logic [63:0] req_addr_o,
   output logic [10:0] req_dw_cnt_o,
   output logic [15:0] req_id_o,
   output logic [7:0] req_tag_o,
   output logic [7:0] req_tgt_fn_o,
   output logic [3:0] req_fbe_o,
   // Identity kept for the completion
   output logic [15:0] cpl_req_id_o,
   output logic [7:0] cpl_tag_o,
   // Payload
   output logic pay_valid_o,
   output logic [`CRD_CHAN_W-1:0] pay_data_o,
   output logic pay_last_o,
   // Completer request channel
   crd_if.host ch
);
   localparam int CW = `CRD_CHAN_W;
   localparam int PW = `CRD_PAD_W;

   typedef struct packed {
      crd_hst_t st;
      logic [1:0] beats;
      logic [PW-1:0] sr;
      logic [3:0] fbe;
      logic tready;
      logic grant;
      logic req_valid;
      logic [3:0] req_type;
      logic [63:0] req_addr;
      logic [10:0] req_dw_cnt;
      logic [15:0] req_id;
      logic [7:0] req_tag;
      logic [7:0] req_tgt_fn;
      logic [3:0] req_fbe;
      logic [15:0] cpl_req_id;
      logic [7:0] cpl_tag;
      logic pay_valid;
      logic [CW-1:0] pay_data;
      logic pay_last;
   } crd_host_st_t;

   crd_host_st_t q, n;

   always_comb begin
      logic [PW+CW-1:0] wide;
      logic [PW-1:0] sr;
      logic [3:0] fbe;
      logic [1:0] lo;
      logic acc;
      n = q;
      acc = ch.tvalid & q.tready;
      wide = {ch.tdata, q.sr} >> CW;
      sr = wide[PW-1:0];
      fbe = ch.tuser[`CRD_USER_SOP] ? ch.tuser[3:0] : q.fbe;
      lo = fbe[0] ? 2'h0 : fbe[1] ? 2'h1 : fbe[2] ? 2'h2 : fbe[3] ? 2'h3 :
         2'h0;
      n.tready = host_ready_i;
      n.grant = np_buf_free_i;
      n.req_valid = 1'b0;
      n.pay_valid = 1'b0;
      case (q.st)
         HS_DESC: begin
            if (acc) begin
               n.sr = sr;
               n.fbe = fbe;
               n.beats = q.beats + 2'h1;
               if (q.beats == 2'(`CRD_DESC_BEATS - 1) || ch.tlast) begin
                  n.beats = 2'h0;
                  n.req_valid = 1'b1;
                  n.req_type = sr[`CRD_TYPE_HI:`CRD_TYPE_LO];
                  n.req_addr = {sr[`CRD_ADDR_HI:`CRD_ADDR_LO], lo};
                  n.req_dw_cnt = sr[`CRD_CNT_HI:`CRD_CNT_LO];
                  n.req_id = sr[`CRD_BUS_HI:`CRD_FN_LO];
                  n.req_tag = sr[`CRD_TAG_HI:`CRD_TAG_LO];
                  n.req_tgt_fn = sr[`CRD_TFN_HI:`CRD_TFN_LO];
                  n.req_fbe = fbe;
                  if (sr[`CRD_TYPE_HI:`CRD_TYPE_LO] != `CRD_TYPE_MEM_WR) begin
                     n.cpl_req_id = sr[`CRD_BUS_HI:`CRD_FN_LO];
                     n.cpl_tag = sr[`CRD_TAG_HI:`CRD_TAG_LO];
                  end
                  n.st = ch.tlast ? HS_DESC : HS_PAY;
               end
            end
         end
         HS_PAY: begin
            if (acc) begin
               n.pay_valid = 1'b1;
               n.pay_data = ch.tdata;
               n.pay_last = ch.tlast;
               if (ch.tlast) begin
                  n.st = HS_DESC;
               end
            end
         end
         default: begin
            n.st = HS_DESC;
         end
      endcase
   end

   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         q <= '0;
         q.st <= HS_DESC;
      end else begin
         q <= n;
      end
   end

   assign ch.tready = q.tready;
   assign ch.credit_grant = q.grant;
   assign req_valid_o = q.req_valid;
   assign req_type_o = q.req_type;
   assign req_addr_o = q.req_addr;
   assign req_dw_cnt_o = q.req_dw_cnt;
   assign req_id_o = q.req_id;
   assign req_tag_o = q.req_tag;
   assign req_tgt_fn_o = q.req_tgt_fn;
   assign req_fbe_o = q.req_fbe;
   assign cpl_req_id_o = q.cpl_req_id;
   assign cpl_tag_o = q.cpl_tag;
   assign pay_valid_o = q.pay_valid;
   assign pay_data_o = q.pay_data;
   assign pay_last_o = q.pay_last;
endmodule
`default_nettype wire

// File: test/crd_properties.sv
// Checks on the completer request stream between the two ends.
// Assumes instantiation beside crd_if, signals joined by name.
`timescale 1ns/10ps
`default_nettype none
`include "crd_defines.svh"
module crd_properties (
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic srst_i,
   // Stream
   input wire logic [`CRD_CHAN_W-1:0] tdata,
   input wire logic tvalid,
   input wire logic tready,
   input wire logic tlast,
   input wire logic [`CRD_USER_W-1:0] tuser,
   input wire logic credit_grant
);
   // ------------------------------------------------------------------
   // Stream assertions
   // ------------------------------------------------------------------
   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (srst_i);
   // High between the first and the last accepted beat of a packet
   logic in_pkt_q;
   always_ff @(posedge ref_clk_i) begin
      in_pkt_q <= !srst_i && (tvalid && tready ? !tlast : in_pkt_q);
   end
   sequence first_taken;
      tvalid && tready && tuser[`CRD_USER_SOP];
   endsequence
   a_beat_held_stable: assert property (
      tvalid && !tready |=> tvalid && $stable(tdata) && $stable(tlast)
      && $stable(tuser)) else $error("beat changed");
   a_start_flag_set: assert property (
      $rose(tvalid) && !in_pkt_q |-> tuser[`CRD_USER_SOP])
      else $error("no start flag");
   a_desc_second_beat: assert property (
      first_taken |=> tvalid && !tuser[`CRD_USER_SOP] && tuser[3:0] == 4'h0)
      else $error("no second beat");
   a_desc_not_last: assert property (
      tvalid && tuser[`CRD_USER_SOP] |-> !tlast)
      else $error("end in descriptor");
   a_count_in_range: assert property (
      first_taken |=> tdata[10:0] <= 11'h100)
      else $error("count above 256");
   a_gap_after_end: assert property (
      tvalid && tready && tlast |=> !tvalid)
      else $error("no gap");
   a_packet_end_bound: assert property (
      first_taken |-> ##[1:300] (tvalid && tready && tlast))
      else $error("no end");
   a_reset_quiet: assert property (disable iff (1'b0)
      srst_i |=> !tvalid && !tlast && !credit_grant)
      else $error("active in reset");
   c_payload_end: cover property (tvalid && tready && tlast && !tuser[4]);
   c_stalled_beat: cover property (tvalid && !tready);
   c_credit_pulse: cover property (credit_grant);
endmodule
`default_nettype wire

// File: test/testbench.sv
// Bench joining device end and client end over the request stream.
// Assumes package, interface, both ends and checker compiled first.
`timescale 1ns/10ps
`default_nettype none
`include "crd_defines.svh"
module testbench
   import crd_pkg::*;
;
   logic ref_clk_i = 1'b0;
   logic srst_i = 1'b1;
   logic ari_en_i = 1'b0;
   logic p_valid_i = 1'b0;
   logic np_valid_i = 1'b0;
   crd_req_t p_req_i = '0;
   crd_req_t np_req_i = '0;
   logic pay_valid_i = 1'b0;
   logic [63:0] pay_data_i = '0;
   logic pay_last_i = 1'b0;
   logic host_ready_i = 1'b1;
   logic np_buf_free_i = 1'b0;
   logic stall_en = 1'b0;
   logic p_ready_o, np_ready_o, pay_ready_o, req_valid_o, pay_valid_o;
   logic pay_last_o;
   logic [3:0] req_type_o, req_fbe_o;
   logic [63:0] req_addr_o, pay_data_o;
   logic [10:0] req_dw_cnt_o;
   logic [15:0] req_id_o, cpl_req_id_o;
   logic [7:0] req_tag_o, req_tgt_fn_o, cpl_tag_o;
   logic [69:0] beat_q[$];
   logic [64:0] pay_q[$];
   int errors = 0;
   int checks = 0;
   int req_n = 0;
   int exp_req = 0;
   crd_if ch_if ();
   crd_dev crd_dev_i (.ref_clk_i, .srst_i, .ari_en_i, .p_valid_i, .p_req_i,
      .p_ready_o, .np_valid_i, .np_req_i, .np_ready_o, .pay_valid_i,
      .pay_data_i, .pay_last_i, .pay_ready_o, .ch(ch_if));
   crd_host crd_host_i (.ref_clk_i, .srst_i, .host_ready_i, .np_buf_free_i,
      .req_valid_o, .req_type_o, .req_addr_o, .req_dw_cnt_o, .req_id_o,
      .req_tag_o, .req_tgt_fn_o, .req_fbe_o, .cpl_req_id_o, .cpl_tag_o,
      .pay_valid_o, .pay_data_o, .pay_last_o, .ch(ch_if));
   crd_properties crd_properties_i (.ref_clk_i, .srst_i,
      .tdata(ch_if.tdata), .tvalid(ch_if.tvalid), .tready(ch_if.tready),
      .tlast(ch_if.tlast), .tuser(ch_if.tuser),
      .credit_grant(ch_if.credit_grant));
   // ------------------------------------------------------------------
   // Clock, monitors and client stall pattern
   // ------------------------------------------------------------------
   always #2.5 ref_clk_i = ~ref_clk_i;
   always @(posedge ref_clk_i) begin
      if (ch_if.tvalid === 1'b1 && ch_if.tready === 1'b1) begin
         beat_q.push_back({ch_if.tuser, ch_if.tlast, ch_if.tdata});
      end
      if (pay_valid_o === 1'b1) begin
         pay_q.push_back({pay_last_o, pay_data_o});
      end
      if (req_valid_o === 1'b1) begin
         req_n++;
      end
      host_ready_i <= stall_en ? ~host_ready_i : 1'b1;
   end
   // ------------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------------
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk_i);
   endtask
   task automatic cmp(input logic [71:0] got, input logic [71:0] exp,
         input string what);
      checks++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED at %0t: %s got %0h exp %0h", $time, what,
            got, exp);
      end
   endtask
   function automatic crd_req_t mkreq(input logic [3:0] t,
         input logic [63:0] a, input logic [10:0] n);
      crd_req_t r;
      r = '0;
      r.layout = CRD_MEM;
      r.req_type = t;
      r.addr = a;
      r.addr64 = 1'b1;
      r.dw_cnt = n;
      r.bus = 8'h5A;
      r.dev = 5'h13;
      r.fn = 8'hC6;
      r.tag = 8'h3C;
      r.tgt_idx = 3'h1;
      r.bar_id = 3'h2;
      r.fbe = 4'h4;
      return r;
   endfunction
   function automatic logic [63:0] desc1(input logic [10:0] n,
         input logic [3:0] t, input logic [15:0] id, input logic [7:0] f,
         input logic [2:0] bar);
      return {13'h0, bar, f, 8'h3C, id, 1'b0, t, n};
   endfunction
   task automatic send(input logic np, input crd_req_t r);
      int n;
      n = 0;
      if (np) np_valid_i <= 1'b1;
      else p_valid_i <= 1'b1;
      if (np) np_req_i <= r;
      else p_req_i <= r;
      @(posedge ref_clk_i);
      while ((np ? np_ready_o : p_ready_o) !== 1'b1 && n < 200) begin
         @(posedge ref_clk_i);
         n++;
      end
      if (np) np_valid_i <= 1'b0;
      else p_valid_i <= 1'b0;
      cmp(n < 200, 1'b1, "header taken");
   endtask
   task automatic push_words(input logic [63:0] base, input int cnt);
      int n;
      n = 0;
      for (int i = 0; i < cnt; i++) begin
         pay_valid_i <= 1'b1;
         pay_data_i <= base + i;
         pay_last_i <= (i == cnt - 1);
         @(posedge ref_clk_i);
         while (pay_ready_o !== 1'b1 && n < 100) begin
            @(posedge ref_clk_i);
            n++;
         end
      end
      pay_valid_i <= 1'b0;
   endtask
   task automatic check_pkt(input logic [63:0] d0, input logic [63:0] d1,
         input logic [3:0] fbe, input int np, input logic [63:0] pb);
      int n;
      logic [69:0] b;
      n = 0;
      while (beat_q.size() < np + 2 && n < 400) begin
         @(posedge ref_clk_i);
         n++;
      end
      cmp(beat_q.size(), np + 2, "beats in packet");
      for (int i = 0; i < np + 2 && beat_q.size() > 0; i++) begin
         b = beat_q.pop_front();
         cmp(b[64], i == np + 1, "end flag");
         if (i == 0) begin
            cmp(b[69:65], {1'b1, fbe}, "start user");
            cmp(b[63:0], d0, "descriptor low");
         end else if (i == 1) begin
            cmp({b[50:16], b[14:0]}, {d1[50:16], d1[14:0]},
               "descriptor high");
         end else begin
            cmp(b[63:0], pb + i - 2, "payload beat");
         end
      end
      tick(3);
      exp_req++;
      cmp(req_n, exp_req, "req delivered");
      cmp(pay_q.size(), np, "client words");
      for (int i = 0; pay_q.size() > 0; i++) begin
         cmp(pay_q.pop_front(), {i == np - 1, pb + i}, "client word");
      end
   endtask
   task automatic host_fields(input logic [63:0] a, input logic [10:0] n,
         input logic [15:0] id, input logic [7:0] f, input logic [3:0] fbe,
         input logic [3:0] t);
      cmp(req_addr_o, a, "byte address");
      cmp(req_dw_cnt_o, n, "dword count");
      cmp(req_id_o, id, "requester id");
      cmp(req_tgt_fn_o, f, "target function");
      cmp(req_fbe_o, fbe, "byte enables");
      cmp(req_type_o, t, "request type");
      cmp(req_tag_o, 8'h3C, "tag");
   endtask
   // ------------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------------
   task automatic test_credit_hold();
      crd_req_t r, w;
      r = mkreq(4'h0, 64'h0000_0001_2345_6780, 11'h002);
      r.addr64 = 1'b0;
      w = mkreq(4'h1, 64'hFEDC_BA98_7654_3210, 11'h002);
      w.addr_type = 2'b10;
      w.has_pay = 1'b1;
      np_valid_i <= 1'b1;
      np_req_i <= r;
      tick(20);
      cmp(beat_q.size(), 0, "np held");
      push_words(64'hA000, 2);
      send(1'b0, w);
      check_pkt(64'hFEDC_BA98_7654_3212, desc1(11'h002, 4'h1, 16'h5A9E,
         8'h01, 3'h2), 4'h4, 2, 64'hA000);
      host_fields(64'hFEDC_BA98_7654_3212, 11'h002, 16'h5A9E, 8'h01, 4'h4,
         4'h1);
      cmp(cpl_tag_o, 8'h00, "write cpl tag");
      cmp(np_ready_o, 1'b0, "read still held");
      np_buf_free_i <= 1'b1;
      tick(1);
      np_buf_free_i <= 1'b0;
      send(1'b1, r);
      check_pkt(64'h0000_0000_2345_6780, desc1(11'h002, 4'h0, 16'h5A9E,
         8'h01, 3'h2), 4'h4, 0, 64'h0);
      host_fields(64'h2345_6782, 11'h002, 16'h5A9E, 8'h01, 4'h4, 4'h0);
      cmp(cpl_req_id_o, 16'h5A9E, "completion id");
      cmp(cpl_tag_o, 8'h3C, "completion tag");
   endtask
   task automatic test_ari_vf();
      crd_req_t r;
      r = mkreq(4'h1, 64'h0000_0040_0000_0100, 11'h100);
      r.tgt_vf = 1'b1;
      r.tgt_idx = 3'h5;
      ari_en_i <= 1'b1;
      send(1'b0, r);
      check_pkt(64'h0000_0040_0000_0100, desc1(11'h100, 4'h1, 16'h5AC6,
         8'h45, 3'h2), 4'h4, 0, 64'h0);
      host_fields(64'h0000_0040_0000_0102, 11'h100, 16'h5AC6, 8'h45, 4'h4,
         4'h1);
      ari_en_i <= 1'b0;
   endtask
   task automatic test_io_zero();
      crd_req_t r, z;
      r = mkreq(4'h2, 64'h1000, 11'h005);
      r.is_io = 1'b1;
      r.addr64 = 1'b0;
      z = mkreq(4'h0, 64'h8000_0040, 11'h000);
      z.zero_len = 1'b1;
      z.fbe = 4'hF;
      z.addr64 = 1'b0;
      np_buf_free_i <= 1'b1;
      tick(2);
      np_buf_free_i <= 1'b0;
      send(1'b1, r);
      check_pkt(64'h1000, desc1(11'h001, 4'h2, 16'h5A9E, 8'h01, 3'h2),
         4'h4, 0, 64'h0);
      host_fields(64'h1002, 11'h001, 16'h5A9E, 8'h01, 4'h4, 4'h2);
      send(1'b1, z);
      check_pkt(64'h8000_0040, desc1(11'h001, 4'h0, 16'h5A9E, 8'h01, 3'h2),
         4'h0, 0, 64'h0);
      host_fields(64'h8000_0040, 11'h001, 16'h5A9E, 8'h01, 4'h0,
         4'h0);
   endtask
   task automatic test_msg_layouts();
      crd_req_t r;
      for (int i = 1; i < 4; i++) begin
         r = mkreq(4'hC, 64'h0, 11'h001);
         r.layout = crd_layout_t'(i);
         r.msg_hdr = 64'h1122_3344_5566_7700 + i;
         r.msg_code = 8'h7E;
         r.msg_route = 3'h2;
         r.fbe = 4'h0;
         send(1'b0, r);
         check_pkt(r.msg_hdr, desc1(11'h001, 4'hC, 16'h5A9E, 8'h7E, 3'h2),
            4'h0, 0, 64'h0);
      end
   endtask
   task automatic test_fifo_full();
      crd_req_t w;
      w = mkreq(4'h1, 64'h2000, 11'h010);
      w.has_pay = 1'b1;
      push_words(64'hB000, `CRD_FIFO_DEPTH);
      tick(1);
      #1;
      cmp(pay_ready_o, 1'b0, "buffer full");
      stall_en <= 1'b1;
      send(1'b0, w);
      check_pkt(64'h2000, desc1(11'h010, 4'h1, 16'h5A9E, 8'h01, 3'h2),
         4'h4, `CRD_FIFO_DEPTH, 64'hB000);
      stall_en <= 1'b0;
      cmp(pay_ready_o, 1'b1, "buffer drained");
   endtask
   task automatic tally_and_finish();
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   initial begin
      tick(6);
      srst_i <= 1'b0;
      tick(2);
      test_credit_hold();
      test_ari_vf();
      test_io_zero();
      test_msg_layouts();
      test_fifo_full();
      tally_and_finish();
   end
   initial begin
      repeat (20000) @(posedge ref_clk_i);
      errors++;
      tally_and_finish();
   end
endmodule
`default_nettype wire
